//--- bench/fcq_flash_model.sv
// Behavioural parallel flash: command modes, identifier and query reads.
// Assumes writes latch on the rising write strobe while chip enable is low.
`timescale 1ns/1ps
`default_nettype none
module fcq_flash_model #(
    parameter logic [15:0] DEV = 16'h00a5, // Arbitrary device code
    parameter logic [15:0] PRI = 16'h0001,
    parameter logic [15:0] EXT = 16'h0031,
    parameter logic [15:0] ALT = 16'h0000
) (
    input  wire logic [23:0] i_addr,
    input  wire logic [15:0] i_dq,
    input  wire logic        i_ce_n,
    input  wire logic        i_oe_n,
    input  wire logic        i_we_n,
    input  wire logic        i_byte_mode,
    input  wire logic        i_bad,
    output logic [15:0]      o_dq,
    output logic [23:0]      o_last_addr,
    output logic [15:0]      o_last_data,
    output logic [23:0]      o_prev_addr,
    output logic [15:0]      o_prev_data
);
    logic [1:0] mode = 2'h0;
    logic       pend = 1'b0;
    logic [7:0] pcmd;
    logic [1:0] lock = 2'h0;
    logic [7:0] w;
    logic [7:0] q;
    logic [15:0] rd;
    // ========================================================
    // Command decode
    always @(posedge i_we_n)
    if (i_ce_n === 1'b0)
    begin
        o_prev_addr <= o_last_addr;
        o_prev_data <= o_last_data;
        o_last_addr <= i_addr;
        o_last_data <= i_dq;
        pend <= 1'b0;
        if (pend && pcmd == 8'h60 && i_dq[7:0] == 8'h01)
            lock[i_addr[16]] <= 1'b1;
        else if (pend && pcmd == 8'h60 && i_dq[7:0] == 8'hd0)
            lock[i_addr[16]] <= 1'b0;
        else if (!pend)
            case (i_dq[7:0])
                8'h90: mode <= 2'h1;
                8'h98: mode <= 2'h2;
                8'hff: mode <= 2'h0;
                8'h70: mode <= 2'h3;
                8'h60, 8'hb8, 8'hc0, 8'h40, 8'h10, 8'he8, 8'h20:
                begin
                    pend <= 1'b1;
                    pcmd <= i_dq[7:0];
                end
                default: ;
            endcase
    end
    // ========================================================
    // Read data; undriven bus shows the inverse pattern
    always_comb
    begin
        w = i_byte_mode ? i_addr[8:1] : i_addr[7:0];
        case (w)
            8'h10: q = 8'h51;
            8'h11: q = 8'h52;
            8'h12: q = i_bad ? 8'h58 : 8'h59;
            8'h13: q = PRI[7:0];
            8'h14: q = PRI[15:8];
            8'h15: q = EXT[7:0];
            8'h16: q = EXT[15:8];
            8'h17: q = ALT[7:0];
            8'h18: q = ALT[15:8];
            default: q = 8'h00;
        endcase
        case (mode)
            2'h0: rd = i_addr[15:0] ^ 16'h5a5a;
            2'h1: rd = (w == 8'h01) ? DEV : (w == 8'h02) ?
                {15'h0000, lock[i_addr[16]]} : 16'h0000;
            2'h2: rd = i_byte_mode ? {~q, q} : {8'h00, q};
            default: rd = 16'h0080;
        endcase
        o_dq = (!i_ce_n && !i_oe_n) ? rd : ~rd;
    end
endmodule // fcq_flash_model
`default_nettype wire

//--- bench/fcq_host_monitor.sv
// Pin and handshake timing checks for the flash host sequencer.
// Assumes it is bound to fcq_host and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module fcq_host_monitor #(
    parameter int AW = 24,
    parameter int DW = 16
) (
    input wire logic          i_sys_clk,
    input wire logic          i_arst_n,
    input wire logic          i_req_valid,
    input wire logic [3:0]    i_req_op,
    input wire logic [AW-1:0] i_req_addr,
    input wire logic [DW-1:0] i_req_data,
    input wire logic          o_req_ready,
    input wire logic          o_rsp_valid,
    input wire logic [AW-1:0] o_flash_addr,
    input wire logic [DW-1:0] o_flash_dq_out,
    input wire logic          o_flash_dq_oe,
    input wire logic          o_flash_ce_n,
    input wire logic          o_flash_oe_n,
    input wire logic          o_flash_we_n
);
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_arst_n);
    // ========================================================
    // Sequences
    sequence s_take(logic [3:0] op);
        i_req_valid && o_req_ready && i_req_op == op;
    endsequence
    sequence s_wr(logic [7:0] c);
        !o_flash_we_n && !o_flash_ce_n && o_flash_dq_oe
            && o_flash_dq_out[7:0] == c;
    endsequence
    // ========================================================
    // Properties
    AST_WE_QUAL: assert property (!o_flash_we_n |-> !o_flash_ce_n
        && o_flash_dq_oe && o_flash_oe_n) else $error("write strobe bad");
    AST_ID_SEQ: assert property (s_take(fcq_pkg::OP_READ_ID)
        |-> ##1 s_wr(8'h90) ##6 o_rsp_valid) else $error("id sequence");
    AST_QRY_CMD: assert property (s_take(fcq_pkg::OP_QUERY)
        |-> ##1 s_wr(8'h98) ##[20:40] o_rsp_valid) else $error("query cmd");
    AST_ARR_CMD: assert property (s_take(fcq_pkg::OP_READ_ARRAY)
        |-> ##1 s_wr(8'hff) ##4 o_rsp_valid) else $error("array cmd");
    AST_ECR_ADDR: assert property (s_take(fcq_pkg::OP_ECR) |-> ##1
        (s_wr(8'h60) ##0 o_flash_addr == $past(i_req_addr)) ##6
        (s_wr(8'h04) ##0 o_flash_addr == $past(i_req_addr, 7)) ##4
        o_rsp_valid) else $error("config register sequence");
    AST_STS_SEQ: assert property (s_take(fcq_pkg::OP_STS_CFG)
        |-> ##1 s_wr(8'hb8) ##6 (!o_flash_we_n
        && o_flash_dq_out == $past(i_req_data, 7)))
        else $error("status pin config");
    AST_LOCK_SEQ: assert property (s_take(fcq_pkg::OP_LOCK)
        |-> ##1 s_wr(8'h60) ##6 s_wr(8'h01)) else $error("lock sequence");
    AST_ERASE_SEQ: assert property (s_take(fcq_pkg::OP_ERASE)
        |-> ##1 s_wr(8'h20) ##6 s_wr(8'hd0) ##4 o_rsp_valid)
        else $error("erase sequence");
    AST_READ_CYC: assert property (s_take(fcq_pkg::OP_READ) |-> ##1
        (!o_flash_oe_n && !o_flash_ce_n && !o_flash_dq_oe) [*3]
        ##1 o_rsp_valid) else $error("read cycle");
    AST_RSP_PULSE: assert property (o_rsp_valid |=> !o_rsp_valid)
        else $error("response longer than one cycle");
endmodule // fcq_host_monitor
bind fcq_host fcq_host_monitor #(.AW(AW), .DW(DW)) u_mon (
    .i_sys_clk(i_sys_clk), .i_arst_n(i_arst_n), .i_req_valid(i_req_valid),
    .i_req_op(i_req_op), .i_req_addr(i_req_addr), .i_req_data(i_req_data),
    .o_req_ready(o_req_ready), .o_rsp_valid(o_rsp_valid),
    .o_flash_addr(o_flash_addr), .o_flash_dq_out(o_flash_dq_out),
    .o_flash_dq_oe(o_flash_dq_oe), .o_flash_ce_n(o_flash_ce_n),
    .o_flash_oe_n(o_flash_oe_n), .o_flash_we_n(o_flash_we_n));
`default_nettype wire

//--- bench/fcq_host_tb.sv
// Self-checking bench for the flash host sequencer.
// Assumes the flash model answers on the far side of the pins.
`timescale 1ns/1ps
`default_nettype none
module fcq_host_tb;
    localparam logic [15:0] DEV = 16'h00a5; // Arbitrary device code
    logic        sys_clk, arst_n, byte_mode, req_valid, bad, err_seen;
    logic [3:0]  req_op;
    logic [23:0] req_addr, fl_addr, last_addr, prev_addr;
    logic [15:0] req_data, rsp_data, dq_out, dq_in, pri, ext, alt;
    logic [15:0] last_data, prev_data;
    logic        req_ready, rsp_valid, rsp_error, qry_valid, lock_flag;
    logic        dq_oe, ce_n, oe_n, we_n;
    int          mismatches, checked, cyc;
    fcq_host u_dut (.i_sys_clk(sys_clk), .i_arst_n(arst_n),
        .i_byte_mode(byte_mode), .i_req_valid(req_valid), .i_req_op(req_op),
        .i_req_addr(req_addr), .i_req_data(req_data), .o_req_ready(req_ready),
        .o_rsp_valid(rsp_valid), .o_rsp_data(rsp_data),
        .o_rsp_error(rsp_error), .o_qry_valid(qry_valid),
        .o_primary_cmdset_code(pri), .o_extended_table_pointer(ext),
        .o_alternate_cmdset_code(alt), .o_block_lock_flag(lock_flag),
        .o_flash_addr(fl_addr), .o_flash_dq_out(dq_out), .o_flash_dq_oe(dq_oe),
        .i_flash_dq_in(dq_in), .o_flash_ce_n(ce_n), .o_flash_oe_n(oe_n),
        .o_flash_we_n(we_n), .i_status_pin(1'b0));
    fcq_flash_model #(.DEV(DEV)) u_dev (.i_addr(fl_addr), .i_dq(dq_out),
        .i_ce_n(ce_n), .i_oe_n(oe_n), .i_we_n(we_n), .i_byte_mode(byte_mode),
        .i_bad(bad), .o_dq(dq_in), .o_last_addr(last_addr),
        .o_last_data(last_data), .o_prev_addr(prev_addr),
        .o_prev_data(prev_data));
    // ========================================================
    // Shared tasks
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        checked++;
        if (got !== exp)
        begin
            mismatches++;
            $display("[FAIL] %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic do_op(input logic [3:0] op, input logic [23:0] a,
                         input logic [15:0] d);
        int n;
        @(posedge sys_clk);
        req_valid <= 1'b1;
        req_op <= op;
        req_addr <= a;
        req_data <= d;
        err_seen <= 1'b0;
        @(posedge sys_clk);
        req_valid <= 1'b0;
        n = 0;
        do
        begin
            @(negedge sys_clk);
            n++;
        end
        while (rsp_valid !== 1'b1 && n < 60);
        chk(n < 60, 1'b1);
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // ========================================================
    // Scenarios
    task automatic t_lock();
        do_op(fcq_pkg::OP_READ_ID, 24'h0, 16'h0);
        chk(rsp_data, DEV);
        chk(last_data, 16'h0090);
        do_op(fcq_pkg::OP_LOCK, 24'h010000, 16'h0);
        chk(prev_data, 16'h0060);
        chk(last_data, 16'h0001);
        do_op(fcq_pkg::OP_READ_ID, 24'h010000, 16'h0);
        chk(lock_flag, 1'b1);
        do_op(fcq_pkg::OP_UNLOCK, 24'h010000, 16'h0);
        chk(last_data, 16'h00d0);
        do_op(fcq_pkg::OP_READ_ID, 24'h010000, 16'h0);
        chk(lock_flag, 1'b0);
        $display("test lock done");
    endtask
    task automatic t_cmds();
        logic [3:0]  op1[5] = '{4'h0, 4'h9, 4'ha, 4'hb, 4'hc};
        logic [7:0]  cd1[5] = '{8'hff, 8'h50, 8'h70, 8'hb0, 8'hd0};
        logic [3:0]  op2[6] = '{4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8};
        logic [7:0]  su[6] = '{8'h60, 8'hb8, 8'hc0, 8'h40, 8'he8, 8'h20};
        logic [15:0] sd[6] = '{16'h0004, 16'h0011, 16'h1234, 16'hbeef,
                               16'h00d0, 16'h00d0};
        for (int i = 0; i < 5; i++)
        begin
            do_op(op1[i], 24'h0, 16'h0);
            chk(last_data, {8'h00, cd1[i]});
        end
        for (int i = 0; i < 6; i++)
        begin
            do_op(op2[i], 24'h000123, sd[i]);
            chk(prev_data, {8'h00, su[i]});
            chk(last_data, sd[i]);
            if (i == 0 || i == 2)
                chk(last_addr, 24'h000123);
            if (i == 0)
                chk(prev_addr, 24'h000123);
        end
        do_op(fcq_pkg::OP_READ_ARRAY, 24'h0, 16'h0);
        do_op(fcq_pkg::OP_READ, 24'h000042, 16'h0);
        chk(rsp_data, 16'h0042 ^ 16'h5a5a);
        $display("test commands done");
    endtask
    task automatic t_query();
        for (int m = 0; m < 3; m++)
        begin
            @(posedge sys_clk);
            byte_mode <= (m == 1);
            bad <= (m == 2);
            do_op(fcq_pkg::OP_QUERY, 24'h0, 16'h0);
            chk(err_seen, m == 2);
            if (m < 2)
            begin
                chk(qry_valid, 1'b1);
                chk(pri, 16'h0001);
                chk(ext, 16'h0031);
                chk(alt, 16'h0000);
            end
        end
        @(posedge sys_clk);
        bad <= 1'b0;
        byte_mode <= 1'b0;
        $display("test query done");
    endtask
    // Reset in mid-query must drop the bus and leave the port usable
    task automatic t_reset();
        @(posedge sys_clk);
        req_valid <= 1'b1;
        req_op <= fcq_pkg::OP_QUERY;
        @(posedge sys_clk);
        req_valid <= 1'b0;
        repeat (6) @(posedge sys_clk);
        arst_n <= 1'b0;
        @(negedge sys_clk);
        chk({req_ready, ce_n, oe_n, we_n, dq_oe, rsp_valid, qry_valid},
            7'h78);
        @(posedge sys_clk);
        arst_n <= 1'b1;
        do_op(fcq_pkg::OP_READ_ARRAY, 24'h0, 16'h0);
        chk(last_data, 16'h00ff);
        $display("test reset done");
    endtask
    // ========================================================
    // Clock, watchdog and main sequence
    initial
    begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk)
    begin
        cyc <= cyc + 1;
        if (rsp_error === 1'b1)
            err_seen <= 1'b1;
        if (cyc == 6000)
        begin
            mismatches++;
            summarize();
        end
    end
    initial
    begin
        {arst_n, byte_mode, req_valid, bad, err_seen} = 5'h00;
        {req_op, req_addr, req_data} = 44'h0;
        {mismatches, checked, cyc} = '0;
        repeat (5) @(posedge sys_clk);
        @(negedge sys_clk);
        chk({req_ready, ce_n, oe_n, we_n, dq_oe, rsp_valid}, 6'h3c);
        @(posedge sys_clk);
        arst_n <= 1'b1;
        t_lock();
        t_cmds();
        t_query();
        t_reset();
        summarize();
    end
endmodule // fcq_host_tb
`default_nettype wire

//--- verilog/fcq_host.sv
// Host-side sequencer that drives flash command writes and reads.
// Assumes flash pins are synchronous to i_sys_clk and a 16-bit data bus.
`timescale 1ns/1ps
`default_nettype none
module fcq_host #(
    parameter int AW = 24,
    parameter int DW = 16
) (
    input  wire logic          i_sys_clk,
    input  wire logic          i_arst_n,
    input  wire logic          i_byte_mode,
    input  wire logic          i_req_valid,
    input  wire logic [3:0]    i_req_op,
    input  wire logic [AW-1:0] i_req_addr,
    input  wire logic [DW-1:0] i_req_data,
    output logic               o_req_ready,
    output logic               o_rsp_valid,
    output logic [DW-1:0]      o_rsp_data,
    output logic               o_rsp_error,
    output logic               o_qry_valid,
    output logic [15:0]        o_primary_cmdset_code,
    output logic [15:0]        o_extended_table_pointer,
    output logic [15:0]        o_alternate_cmdset_code,
    output logic               o_block_lock_flag,
    output logic [AW-1:0]      o_flash_addr,
    output logic [DW-1:0]      o_flash_dq_out,
    output logic               o_flash_dq_oe,
    input  wire logic [DW-1:0] i_flash_dq_in,
    output logic               o_flash_ce_n,
    output logic               o_flash_oe_n,
    output logic               o_flash_we_n,
    input  wire logic          i_status_pin
);
    // ========================================================
    // Helpers
    function automatic logic [7:0] fcq_cmd(input logic [3:0] op);
        case (op)
            fcq_pkg::OP_READ_ID:    fcq_cmd = fcq_pkg::CMD_READ_ID;
            fcq_pkg::OP_QUERY:      fcq_cmd = fcq_pkg::CMD_QUERY;
            fcq_pkg::OP_ECR:        fcq_cmd = fcq_pkg::CMD_ECR_SETUP;
            fcq_pkg::OP_STS_CFG:    fcq_cmd = fcq_pkg::CMD_STS_SETUP;
            fcq_pkg::OP_OTP:        fcq_cmd = fcq_pkg::CMD_OTP_SETUP;
            fcq_pkg::OP_PROG:       fcq_cmd = fcq_pkg::CMD_PROG_WORD;
            fcq_pkg::OP_BUF_PROG:   fcq_cmd = fcq_pkg::CMD_BUF_SETUP;
            fcq_pkg::OP_ERASE:      fcq_cmd = fcq_pkg::CMD_ERASE_SETUP;
            fcq_pkg::OP_CLR_STATUS: fcq_cmd = fcq_pkg::CMD_CLR_STATUS;
            fcq_pkg::OP_RD_STATUS:  fcq_cmd = fcq_pkg::CMD_READ_STATUS;
            fcq_pkg::OP_SUSPEND:    fcq_cmd = fcq_pkg::CMD_SUSPEND;
            fcq_pkg::OP_RESUME:     fcq_cmd = fcq_pkg::CMD_CONFIRM;
            fcq_pkg::OP_LOCK:       fcq_cmd = fcq_pkg::CMD_ECR_SETUP;
            fcq_pkg::OP_UNLOCK:     fcq_cmd = fcq_pkg::CMD_ECR_SETUP;
            default:                fcq_cmd = fcq_pkg::CMD_READ_ARRAY;
        endcase
    endfunction
    // Second-cycle data; ops without a fixed confirm send the request data
    function automatic logic [DW-1:0] fcq_cfm(input logic [3:0] op,
                                              input logic [DW-1:0] d);
        case (op)
            fcq_pkg::OP_ECR:      fcq_cfm = DW'(fcq_pkg::CMD_ECR_CONFIRM);
            fcq_pkg::OP_BUF_PROG: fcq_cfm = DW'(fcq_pkg::CMD_CONFIRM);
            fcq_pkg::OP_ERASE:    fcq_cfm = DW'(fcq_pkg::CMD_CONFIRM);
            fcq_pkg::OP_LOCK:     fcq_cfm = DW'(fcq_pkg::CMD_LOCK_CONFIRM);
            fcq_pkg::OP_UNLOCK:   fcq_cfm = DW'(fcq_pkg::CMD_CONFIRM);
            default:              fcq_cfm = d;
        endcase
    endfunction
    function automatic logic fcq_two(input logic [3:0] op);
        fcq_two = (op == fcq_pkg::OP_ECR) || (op == fcq_pkg::OP_STS_CFG) ||
                  (op == fcq_pkg::OP_OTP) || (op == fcq_pkg::OP_PROG) ||
                  (op == fcq_pkg::OP_BUF_PROG) ||
                  (op == fcq_pkg::OP_ERASE) ||
                  (op == fcq_pkg::OP_LOCK) || (op == fcq_pkg::OP_UNLOCK);
    endfunction
    // Word offset to pin address; x8 parts shift it up one line, low line held at 0
    function automatic logic [AW-1:0] fcq_addr(input logic [AW-1:0] w,
                                               input logic byte_mode);
        fcq_addr = byte_mode ? {w[AW-2:0], 1'b0} : w;
    endfunction
    // ========================================================
    // State
    fcq_pkg::fcq_state_t state, next_state;
    logic [3:0]    op, next_op;
    logic [AW-1:0] addr, next_addr;
    logic [DW-1:0] data, next_data;
    logic [3:0]    tcnt, next_tcnt;
    logic [3:0]    qidx, next_qidx;
    logic [7:0]    qbuf [0:fcq_pkg::QRY_FIELD_WORDS-1];
    logic [7:0]    next_qbyte;
    logic          qwe;
    logic          rsp_v, next_rsp_v;
    logic [DW-1:0] rsp_d, next_rsp_d;
    logic          rsp_e, next_rsp_e;
    logic          qv, next_qv;
    logic          lockf, next_lockf;
    logic          t_done;

    assign t_done = (tcnt == 4'(fcq_pkg::T_CYCLES - 1));
    // ========================================================
    // Sequencer
    always_comb
    begin
        next_state = state;
        next_op    = op;
        next_addr  = addr;
        next_data  = data;
        next_tcnt  = (state == fcq_pkg::ST_IDLE) ? 4'h0 : tcnt + 4'h1;
        next_qidx  = qidx;
        next_rsp_v = 1'b0;
        next_rsp_d = rsp_d;
        next_rsp_e = 1'b0;
        next_qv    = qv;
        next_lockf = lockf;
        next_qbyte = i_flash_dq_in[7:0];
        qwe        = 1'b0;
        case (state)
            fcq_pkg::ST_IDLE:
                if (i_req_valid)
                begin
                    next_op   = i_req_op;
                    next_addr = i_req_addr;
                    next_data = i_req_data;
                    next_tcnt = 4'h0;
                    if (i_req_op == fcq_pkg::OP_READ)
                        next_state = fcq_pkg::ST_RD;
                    else
                        next_state = fcq_pkg::ST_WR1;
                    if (i_req_op == fcq_pkg::OP_QUERY)
                    begin
                        next_qidx = 4'h0;
                        next_qv   = 1'b0;
                    end
                end
            fcq_pkg::ST_WR1:
                if (t_done)
                begin
                    next_tcnt = 4'h0;
                    if (fcq_two(op))
                        next_state = fcq_pkg::ST_GAP;
                    else if (op == fcq_pkg::OP_QUERY)
                        next_state = fcq_pkg::ST_QRY;
                    else if (op == fcq_pkg::OP_READ_ID)
                    begin
                        // Lock probe when an address is given, else code
                        next_addr = (addr == '0) ?
                            AW'(fcq_pkg::ID_DEVICE_OFS) :
                            addr + AW'(fcq_pkg::ID_LOCK_OFS);
                        next_state = fcq_pkg::ST_RD;
                    end
                    else
                        next_state = fcq_pkg::ST_DONE;
                end
            fcq_pkg::ST_GAP:
                if (t_done)
                begin
                    next_tcnt  = 4'h0;
                    next_state = fcq_pkg::ST_WR2;
                end
            fcq_pkg::ST_WR2:
                if (t_done)
                    next_state = fcq_pkg::ST_DONE;
            fcq_pkg::ST_RD:
                if (t_done)
                begin
                    next_rsp_v = 1'b1;
                    next_rsp_d = i_flash_dq_in;
                    if (op == fcq_pkg::OP_READ_ID &&
                        addr != AW'(fcq_pkg::ID_DEVICE_OFS))
                        next_lockf = i_flash_dq_in[0];
                    next_state = fcq_pkg::ST_IDLE;
                end
            fcq_pkg::ST_QRY:
                if (t_done)
                begin
                    next_tcnt = 4'h0;
                    qwe       = 1'b1;
                    // Upper byte must read zero on every location in x16
                    if (!i_byte_mode && i_flash_dq_in[DW-1:8] != '0)
                        next_rsp_e = 1'b1;
                    if (qidx == 4'h0 && next_qbyte != fcq_pkg::QRY_CH_Q)
                        next_rsp_e = 1'b1;
                    if (qidx == 4'h1 && next_qbyte != fcq_pkg::QRY_CH_R)
                        next_rsp_e = 1'b1;
                    if (qidx == 4'h2 && next_qbyte != fcq_pkg::QRY_CH_Y)
                        next_rsp_e = 1'b1;
                    if (qidx == 4'(fcq_pkg::QRY_FIELD_WORDS - 1))
                    begin
                        next_qv    = 1'b1;
                        next_rsp_v = 1'b1;
                        next_state = fcq_pkg::ST_IDLE;
                    end
                    else
                        next_qidx = qidx + 4'h1;
                end
            fcq_pkg::ST_DONE:
            begin
                next_rsp_v = 1'b1;
                next_state = fcq_pkg::ST_IDLE;
            end
            default:
                next_state = fcq_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge i_sys_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            state       <= fcq_pkg::ST_IDLE;
            op          <= 4'h0;
            addr        <= '0;
            data        <= '0;
            tcnt        <= 4'h0;
            qidx        <= 4'h0;
            rsp_v       <= 1'b0;
            rsp_d       <= '0;
            rsp_e       <= 1'b0;
            qv          <= 1'b0;
            lockf       <= 1'b0;
        end
        else
        begin
            state       <= next_state;
            op          <= next_op;
            addr        <= next_addr;
            data        <= next_data;
            tcnt        <= next_tcnt;
            qidx        <= next_qidx;
            rsp_v       <= next_rsp_v;
            rsp_d       <= next_rsp_d;
            rsp_e       <= next_rsp_e;
            qv          <= next_qv;
            lockf       <= next_lockf;
        end
    end

    // Query bytes held without reset; qv marks them valid
    always_ff @(posedge i_sys_clk)
    begin
        if (qwe)
            qbuf[qidx] <= next_qbyte;
    end
    // ========================================================
    // Pins
    always_comb
    begin
        o_flash_ce_n   = (state == fcq_pkg::ST_IDLE) ||
                         (state == fcq_pkg::ST_GAP) ||
                         (state == fcq_pkg::ST_DONE);
        o_flash_we_n   = !((state == fcq_pkg::ST_WR1) ||
                           (state == fcq_pkg::ST_WR2)) || t_done;
        o_flash_oe_n   = !((state == fcq_pkg::ST_RD) ||
                           (state == fcq_pkg::ST_QRY));
        o_flash_dq_oe  = (state == fcq_pkg::ST_WR1) ||
                         (state == fcq_pkg::ST_WR2);
        o_flash_dq_out = (state == fcq_pkg::ST_WR2) ?
                         fcq_cfm(op, data) :
                         DW'(fcq_cmd(op));
        if (state == fcq_pkg::ST_QRY)
            o_flash_addr = fcq_addr(AW'(fcq_pkg::QRY_BASE) + AW'(qidx),
                                    i_byte_mode);
        else
            o_flash_addr = addr;
    end

    assign o_req_ready = (state == fcq_pkg::ST_IDLE);
    assign o_rsp_valid = rsp_v;
    assign o_rsp_data  = rsp_d;
    assign o_rsp_error = rsp_e;
    assign o_qry_valid = qv;
    assign o_block_lock_flag = lockf;
    // Little-endian pairs at rising offsets
    assign o_primary_cmdset_code    = {qbuf[4], qbuf[3]};
    assign o_extended_table_pointer = {qbuf[6], qbuf[5]};
    assign o_alternate_cmdset_code  = {qbuf[8], qbuf[7]};
endmodule // fcq_host
`default_nettype wire

//--- verilog/fcq_pkg.sv
// Constants for the flash command and query host controller.
// Assumes an asynchronous parallel NOR flash with a 16-bit data bus.
`default_nettype none
package fcq_pkg;
    // ========================================================
    // Command codes
    localparam logic [7:0] CMD_READ_ID      = 8'h90;
    localparam logic [7:0] CMD_QUERY        = 8'h98;
    localparam logic [7:0] CMD_READ_ARRAY   = 8'hff;
    localparam logic [7:0] CMD_ECR_SETUP    = 8'h60;
    localparam logic [7:0] CMD_ECR_CONFIRM  = 8'h04;
    localparam logic [7:0] CMD_STS_SETUP    = 8'hb8;
    localparam logic [7:0] CMD_OTP_SETUP    = 8'hc0;
    localparam logic [7:0] CMD_PROG_WORD    = 8'h40;
    localparam logic [7:0] CMD_PROG_ALT     = 8'h10;
    localparam logic [7:0] CMD_BUF_SETUP    = 8'he8;
    localparam logic [7:0] CMD_CONFIRM      = 8'hd0;
    localparam logic [7:0] CMD_ERASE_SETUP  = 8'h20;
    localparam logic [7:0] CMD_CLR_STATUS   = 8'h50;
    localparam logic [7:0] CMD_READ_STATUS  = 8'h70;
    localparam logic [7:0] CMD_SUSPEND      = 8'hb0;
    localparam logic [7:0] CMD_LOCK_CONFIRM = 8'h01;
    // ========================================================
    // Identifier and query offsets (word units)
    localparam logic [7:0] ID_DEVICE_OFS    = 8'h01;
    localparam logic [7:0] ID_LOCK_OFS      = 8'h02;
    localparam logic [7:0] QRY_BASE         = 8'h10;
    localparam logic [7:0] QRY_PRI_OFS      = 8'h13;
    localparam logic [7:0] QRY_EXT_OFS      = 8'h15;
    localparam logic [7:0] QRY_ALT_OFS      = 8'h17;
    localparam logic [7:0] QRY_CH_Q         = 8'h51;
    localparam logic [7:0] QRY_CH_R         = 8'h52;
    localparam logic [7:0] QRY_CH_Y         = 8'h59;
    localparam int         QRY_FIELD_WORDS  = 9;
    // ========================================================
    // Bus timing
    localparam int CLK_NS      = 25;
    localparam int T_CYCLE_NS  = 75;
    localparam int T_CYCLES    = (T_CYCLE_NS + CLK_NS - 1) / CLK_NS;
    // ========================================================
    // Operations requested by the user side
    typedef enum logic [3:0] {
        OP_READ_ARRAY = 4'h0,
        OP_READ_ID    = 4'h1,
        OP_QUERY      = 4'h2,
        OP_ECR        = 4'h3,
        OP_STS_CFG    = 4'h4,
        OP_OTP        = 4'h5,
        OP_PROG       = 4'h6,
        OP_BUF_PROG   = 4'h7,
        OP_ERASE      = 4'h8,
        OP_CLR_STATUS = 4'h9,
        OP_RD_STATUS  = 4'ha,
        OP_SUSPEND    = 4'hb,
        OP_RESUME     = 4'hc,
        OP_LOCK       = 4'hd,
        OP_UNLOCK     = 4'he,
        OP_READ       = 4'hf
    } fcq_op_t;
    typedef enum logic [6:0] {
        ST_IDLE  = 7'h01,
        ST_WR1   = 7'h02,
        ST_GAP   = 7'h04,
        ST_WR2   = 7'h08,
        ST_RD    = 7'h10,
        ST_QRY   = 7'h20,
        ST_DONE  = 7'h40
    } fcq_state_t;
endpackage
`default_nettype wire
